// *** dv/dst_far_model.sv ***
// far side model: source sensing front end and the power switches
// assumes the bench sets wanted source states just after clk rises
module dst_far_model
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire dst_pkg::dst_src_t cmd_n, // wanted normal state
    input wire dst_pkg::dst_src_t cmd_a, // wanted alternate state
    input wire logic cmd_match, // wanted phase result
    input wire logic sw_norm_on, // normal switch drive
    input wire logic sw_alt_on, // alternate switch drive
    output dst_pkg::dst_src_t src_n, // sensed normal flags
    output dst_pkg::dst_src_t src_a, // sensed alternate flags
    output logic phase_match, // sensed phase result
    output logic overlap // both switches seen on
);
    timeunit 1ns;
    timeprecision 1ns;
    import dst_pkg::*;
    // one sample a cycle, so no flag ever changes between edges
    always_ff @(posedge clk)
    begin
        src_n <= cmd_n;
        src_a <= cmd_a;
        phase_match <= cmd_match;
    end
    // both switches on would tie the two buses together
    always_ff @(posedge clk)
    begin
        overlap <= !sys_rst && (overlap || (sw_norm_on && sw_alt_on));
    end
endmodule : dst_far_model

// *** dv/dual_source_transfer_control_bench.sv ***
// self-checking bench for the dual source transfer controller
// assumes dst_far_model stands in for the sensing and the switches
module dual_source_transfer_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dst_pkg::*;
    // GOOD meets pickups on voltage and both frequency windows; DOWN and RND only the frequency ones
    localparam dst_src_t GOOD = 12'h850;
    localparam dst_src_t DOWN = 12'h450;
    localparam dst_src_t RND = 12'h650;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dst_src_t cmd_n = GOOD;
    dst_src_t cmd_a = GOOD;
    dst_src_t src_n;
    dst_src_t src_a;
    logic cmd_match = 1'b1;
    logic phase_match;
    logic overlap;
    logic fan_fail = 1'b0;
    logic maint_clr = 1'b0;
    logic manual = 1'b0;
    logic man_sel = 1'b0;
    logic pref_sel = 1'b0;
    logic retx_en = 1'b0;
    logic pad_en = 1'b0;
    logic freq_en = 1'b1;
    logic fpp_en = 1'b0;
    logic alarm_en = 1'b1;
    logic [15:0] ctl_dly = 16'h0000;
    logic [15:0] xfer_dly = 16'h0000;
    logic [15:0] rnd_dly = 16'h0000;
    logic [15:0] retx_time = 16'h0000;
    logic sw_norm_on;
    logic sw_alt_on;
    logic [1:0] ind_avail;
    logic ind_active;
    logic ind_pref;
    logic ind_retx;
    logic inhibit;
    logic alarm;
    logic [3:0] fault_code;
    logic [11:0] fq [6] = '{12'h890, 12'h810, 12'h850,
                            12'h860, 12'h840, 12'h850};
    int fails = 0;
    int compares = 0;

    initial
    begin
        forever #25 clk = ~clk;
    end

    dst_far_model far (.clk(clk), .sys_rst(sys_rst), .cmd_n(cmd_n),
        .cmd_a(cmd_a), .cmd_match(cmd_match), .sw_norm_on(sw_norm_on),
        .sw_alt_on(sw_alt_on), .src_n(src_n), .src_a(src_a),
        .phase_match(phase_match), .overlap(overlap));

    dst_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .src_n(src_n),
        .src_a(src_a), .phase_match(phase_match), .fan_fail(fan_fail),
        .maint_clr(maint_clr), .manual(manual), .man_sel(man_sel),
        .pref_sel(pref_sel), .retx_en(retx_en), .pad_en(pad_en),
        .freq_en(freq_en), .fpp_en(fpp_en), .alarm_en(alarm_en),
        .ctl_dly(ctl_dly), .xfer_dly(xfer_dly), .rnd_dly(rnd_dly),
        .retx_time(retx_time), .sw_norm_on(sw_norm_on),
        .sw_alt_on(sw_alt_on), .ind_avail(ind_avail),
        .ind_active(ind_active), .ind_pref(ind_pref),
        .ind_retx(ind_retx), .inhibit(inhibit), .alarm(alarm),
        .fault_code(fault_code));

    task wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task ck(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : ck

    task rng(input int v, input int lo, input int hi);
        compares++;
        if (v < lo || v > hi)
        begin
            fails++;
            $display("Error at %0t: count %0d out of range", $time, v);
        end
    endtask : rng

    task put(input dst_src_t n, input dst_src_t a, input logic m);
        @(posedge clk);
        cmd_n <= n;
        cmd_a <= a;
        cmd_match <= m;
    endtask : put

    task rst(input int c, input int x, input int r, input int q,
             input logic p);
        @(posedge clk);
        sys_rst <= 1'b1;
        cmd_n <= GOOD;
        cmd_a <= GOOD;
        cmd_match <= 1'b1;
        {manual, man_sel, pref_sel, retx_en, fpp_en} <= 5'h00;
        alarm_en <= 1'b1;
        pad_en <= p;
        ctl_dly <= 16'(c);
        xfer_dly <= 16'(x);
        rnd_dly <= 16'(r);
        retx_time <= 16'(q);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : rst

    task clr;
        @(posedge clk);
        maint_clr <= 1'b1;
        @(posedge clk);
        maint_clr <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : clr

    // counts cycles to completion and cycles with both switches open
    task wait_act(input logic want, output int t, output int g);
        t = 0;
        g = 0;
        // look only at falling edges, where the outputs have settled
        do
        begin
            @(negedge clk);
            t++;
            if (sw_norm_on === 1'b0 && sw_alt_on === 1'b0)
                g++;
            if (t > 60)
            begin
                fails++;
                $display("Error at %0t: switch-over never came", $time);
                wrap_up;
            end
        end
        while (!(ind_active === want && sw_alt_on === want
                 && sw_norm_on === !want));
    endtask : wait_act

    initial
    begin
        int t;
        int g;
        rst(0, 0, 0, 0, 1'b0);
        repeat (2) @(negedge clk);
        ck(sw_norm_on, 1'b1);
        ck(ind_active, SRC_NORM);
        ck(ind_avail, 2'b11);
        ck(fault_code, FC_NONE);
        ck(ind_retx, 1'b0);
        @(posedge clk);
        pref_sel <= SRC_ALT;
        retx_en <= 1'b1;
        @(negedge clk);
        ck(ind_pref, SRC_ALT);
        ck(ind_retx, 1'b1);
        rst(3, 2, 0, 0, 1'b1);
        put(DOWN, GOOD, 1'b1);
        wait_act(SRC_ALT, t, g);
        // one sensing stage, three cycles of delay, one switch register, two of gap
        rng(t, 7, 9);
        rng(g, 2, 3);
        ck(ind_avail, 2'b10);
        ck(alarm, 1'b1);
        ck(fault_code, FC_VOLT);
        @(posedge clk);
        alarm_en <= 1'b0;
        repeat (2) @(negedge clk);
        ck(alarm, 1'b0);
        put(GOOD, GOOD, 1'b1);
        repeat (15) @(negedge clk);
        ck(fault_code, FC_NONE);
        ck(ind_active, SRC_ALT);
        rst(3, 2, 0, 0, 1'b1);
        put(DOWN, GOOD, 1'b0);
        repeat (12) @(negedge clk);
        ck(sw_norm_on, 1'b1);
        put(DOWN, GOOD, 1'b1);
        wait_act(SRC_ALT, t, g);
        rst(8, 0, 0, 0, 1'b0);
        put(DOWN, GOOD, 1'b0);
        wait_act(SRC_ALT, t, g);
        rng(t, 1, 5);
        rng(g, 0, 1);
        rst(1, 1, 4, 0, 1'b1);
        put(RND, GOOD, 1'b0);
        wait_act(SRC_ALT, t, g);
        rng(g, 4, 6);
        for (int k = 0; k < 2; k++)
        begin
            rst(0, 0, 0, 0, 1'b0);
            put(RND | (k ? 12'h004 : 12'h008), GOOD, 1'b1);
            repeat (12) @(negedge clk);
            ck(ind_active, SRC_NORM);
            ck(inhibit, 1'b1);
            ck(fault_code, FC_LOAD);
        end
        for (int k = 0; k < 6; k++)
        begin
            if (k % 3 == 0)
                rst(0, 0, 0, 0, 1'b0);
            put(GOOD, fq[k], 1'b1);
            repeat (4) @(negedge clk);
            ck(ind_avail[1], k % 3 == 2);
        end
        // frequency sensing off: an over-frequency flag is ignored
        rst(0, 0, 0, 0, 1'b0);
        @(posedge clk);
        freq_en <= 1'b0;
        put(GOOD, fq[0], 1'b1);
        repeat (3) @(negedge clk);
        ck(ind_avail[1], 1'b1);
        @(posedge clk);
        freq_en <= 1'b1;
        rst(0, 0, 0, 0, 1'b0);
        put(GOOD, 12'h050, 1'b1);
        repeat (3) @(negedge clk);
        ck(ind_avail, 2'b01);
        put(GOOD, 12'h852, 1'b1);
        // open latch, then the registered readout: one stage more
        repeat (4) @(negedge clk);
        ck(ind_avail, 2'b01);
        ck(fault_code, FC_OPEN);
        put(GOOD, GOOD, 1'b1);
        repeat (5) @(negedge clk);
        ck(alarm, 1'b1);
        clr;
        ck(fault_code, FC_NONE);
        @(posedge clk);
        fan_fail <= 1'b1;
        @(posedge clk);
        fan_fail <= 1'b0;
        repeat (3) @(negedge clk);
        ck(fault_code, FC_FAN);
        ck(sw_norm_on, 1'b1);
        clr;
        ck(alarm, 1'b0);
        rst(0, 0, 0, 6, 1'b0);
        @(posedge clk);
        fpp_en <= 1'b1;
        retx_en <= 1'b1;
        put(12'h950, GOOD, 1'b1);
        wait_act(SRC_ALT, t, g);
        repeat (15) @(negedge clk);
        ck(ind_active, SRC_ALT);
        put(GOOD, GOOD, 1'b1);
        wait_act(SRC_NORM, t, g);
        // six qualified cycles between the sensing stage and the switch register
        rng(t, 8, 10);
        rst(0, 1, 0, 0, 1'b0);
        put(GOOD, 12'h851, 1'b1);
        wait_act(SRC_ALT, t, g);
        ck(fault_code, FC_SHORT);
        put(GOOD, 12'h451, 1'b1);
        repeat (15) @(negedge clk);
        ck(ind_active, SRC_ALT);
        rst(0, 0, 0, 0, 1'b0);
        // manual selection of a source that is already down
        put(GOOD, 12'h450, 1'b1);
        @(posedge clk);
        manual <= 1'b1;
        man_sel <= SRC_ALT;
        wait_act(SRC_ALT, t, g);
        ck(overlap, 1'b0);
        repeat (5) @(negedge clk);
        ck(ind_active, SRC_ALT);
        wrap_up;
    end
endmodule : dual_source_transfer_control_bench

// *** logic/dst_ctrl.sv ***
// transfer decision, timing and indication for a two-source switch
// assumes sensing flags and settings are levels on clk; delays in cycles
module dst_ctrl
#(
    parameter int DW = dst_pkg::DLY_W
)
(
    input wire logic clk,                         // system clock
    input wire logic sys_rst,                     // sync reset, high
    input wire dst_pkg::dst_src_t src_n,          // normal source flags
    input wire dst_pkg::dst_src_t src_a,          // alternate flags
    input wire logic phase_match,                 // mismatch below preset
    input wire logic fan_fail,                    // fan failure
    input wire logic maint_clr,                   // clear latched faults
    input wire logic manual,                      // manual mode
    input wire logic man_sel,                     // manual source, 1 alt
    input wire logic pref_sel,                    // preferred, 1 alt
    input wire logic retx_en,                     // retransfer enabled
    input wire logic pad_en,                      // phase angle feature
    input wire logic freq_en,                     // frequency sensing on
    input wire logic fpp_en,                      // full phase protection
    input wire logic alarm_en,                    // audible alarm enabled
    input wire logic [DW-1:0] ctl_dly,            // control delay
    input wire logic [DW-1:0] xfer_dly,           // transfer delay
    input wire logic [DW-1:0] rnd_dly,            // random transfer wait
    input wire logic [DW-1:0] retx_time,          // retransfer interval
    output logic sw_norm_on,                      // drive normal switches
    output logic sw_alt_on,                       // drive alternate switches
    output logic [1:0] ind_avail,                 // [0] normal [1] alt
    output logic ind_active,                      // active source, 1 alt
    output logic ind_pref,                        // preferred, 1 alt
    output logic ind_retx,                        // retransfer enabled
    output logic inhibit,                         // transfer inhibited
    output logic alarm,                           // audible alarm
    output logic [3:0] fault_code                 // readout code
);
    import dst_pkg::*;

    function automatic logic pick(input logic [1:0] v, input logic i);
        pick = i ? v[1] : v[0];
    endfunction : pick

    dst_state_t st_r;
    dst_state_t st_nxt;
    logic act_r;
    logic act_nxt;
    logic tgt_r;
    logic tgt_nxt;
    logic [DW-1:0] cd_r;
    logic [DW-1:0] cd_nxt;
    logic [DW-1:0] gc_r;
    logic [DW-1:0] gc_nxt;
    logic [1:0] open_r;
    logic [1:0] short_r;
    logic fan_r;
    logic [1:0] avail;
    logic [1:0] fbad;
    logic [1:0] rtok;
    logic sw_n_r;
    logic sw_a_r;
    logic inh_r;
    logic alarm_r;
    logic [3:0] fc_r;
    logic [3:0] fc_nxt;
    dst_src_t flg [2];

    assign flg[0] = src_n;
    assign flg[1] = src_a;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_src
            dst_src_qual #(.DW(DW)) u_qual (
                .clk(clk),
                .sys_rst(sys_rst),
                .flg(flg[g]),
                .freq_en(freq_en),
                .fpp_en(fpp_en),
                .retx_time(retx_time),
                .avail(avail[g]),
                .freq_bad(fbad[g]),
                .retx_ok(rtok[g])
            );
        end
    endgenerate

    // active and inactive source conditions
    wire logic [1:0] inph_v = {src_a.below_inph, src_n.below_inph};
    wire logic [1:0] rnd_v = {src_a.below_rnd, src_n.below_rnd};
    wire logic [1:0] plow_v = {src_a.phase_low, src_n.phase_low};
    wire logic [1:0] ovl_v = {src_a.ovl_avg | src_a.ovl_peak,
                              src_n.ovl_avg | src_n.ovl_peak};
    wire logic [1:0] opn_v = {src_a.sw_open, src_n.sw_open};
    wire logic [1:0] sht_v = {src_a.sw_short, src_n.sw_short};
    wire logic uv_in = pick(inph_v, act_r) |
                       (fpp_en & pick(plow_v, act_r));
    wire logic uv_rnd = pick(rnd_v, act_r);
    wire logic act_hard = pick(fbad, act_r) | pick(opn_v, act_r);
    wire logic inact_av = pick(avail, ~act_r);
    wire logic cd_done = uv_in & (cd_r >= ctl_dly);
    wire logic inph_mode = cd_done & ~uv_rnd;
    wire logic load_flt = pick(ovl_v, act_r) & uv_rnd;
    wire logic short_lk = |short_r;
    wire logic short_src = short_r[1];
    // phase feature off: no delay and no mismatch check
    wire logic inph_go = pad_en ? (inph_mode & phase_match)
                                : uv_in;
    wire logic act_bad = uv_rnd | inph_go | act_hard
                         | (~pad_en & uv_in);
    wire logic rnd_go = uv_rnd & cd_done;
    wire logic auto_go = ~manual & ~short_lk & ~load_flt & inact_av
                         & (rnd_go | inph_go | act_hard);
    wire logic retx_go = ~manual & ~short_lk & ~load_flt & retx_en
                         & (act_r != pref_sel) & ~act_bad
                         & pick(rtok, pref_sel)
                         & (~pad_en | phase_match);
    wire logic man_go = manual & (act_r != man_sel);
    wire logic ovr_go = short_lk & (act_r != short_src);
    wire logic start = (st_r == ST_RUN) &
                       (ovr_go | man_go | auto_go | retx_go);
    wire logic is_rnd = auto_go & uv_rnd & ~ovr_go & ~man_go;
    wire logic [DW-1:0] gap_len = is_rnd ? rnd_dly : xfer_dly;
    wire logic gap_zero = (gap_len == '0);
    wire logic gap_done = (st_r == ST_GAP) & (gc_r == '0);
    wire logic src_flt = act_bad | act_hard | ~inact_av;

    // control delay: counts only while dip is uninterrupted
    assign cd_nxt = ~uv_in ? '0 : (cd_r == '1) ? cd_r : cd_r + 1'b1;

    always_comb
    begin
        st_nxt = st_r;
        act_nxt = act_r;
        tgt_nxt = tgt_r;
        gc_nxt = gc_r;
        case (st_r)
            ST_RUN:
            begin
                if (start)
                begin
                    tgt_nxt = ~act_r;
                    if (gap_zero)
                        act_nxt = ~act_r;
                    else
                    begin
                        st_nxt = ST_GAP;
                        gc_nxt = gap_len - 1'b1;
                    end
                end
            end
            ST_GAP:
            begin
                if (gap_done)
                begin
                    act_nxt = tgt_r;
                    st_nxt = ST_RUN;
                end
                else
                    gc_nxt = gc_r - 1'b1;
            end
            default:
                st_nxt = ST_RUN;
        endcase
    end

    // priority of readout: internal before source faults
    assign fc_nxt = short_lk ? FC_SHORT
                  : (|open_r) ? FC_OPEN
                  : fan_r ? FC_FAN
                  : load_flt ? FC_LOAD
                  : (|fbad) ? FC_FREQ
                  : (src_flt | ~(&avail)) ? FC_VOLT
                  : FC_NONE;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= ST_RUN;
            act_r <= SRC_NORM;
            tgt_r <= SRC_NORM;
            cd_r <= '0;
            gc_r <= '0;
            open_r <= 2'b00;
            short_r <= 2'b00;
            fan_r <= 1'b0;
            sw_n_r <= 1'b0;
            sw_a_r <= 1'b0;
            inh_r <= 1'b0;
            alarm_r <= 1'b0;
            fc_r <= FC_NONE;
        end
        else
        begin
            st_r <= st_nxt;
            act_r <= act_nxt;
            tgt_r <= tgt_nxt;
            cd_r <= cd_nxt;
            gc_r <= gc_nxt;
            // set wins over maintenance clear
            open_r <= (open_r & {2{~maint_clr}}) | opn_v;
            short_r <= (short_r & {2{~maint_clr}}) | sht_v;
            fan_r <= (fan_r & ~maint_clr) | fan_fail;
            sw_n_r <= (st_nxt == ST_RUN) & (act_nxt == SRC_NORM);
            sw_a_r <= (st_nxt == ST_RUN) & (act_nxt == SRC_ALT);
            inh_r <= load_flt | short_lk | (act_bad & ~inact_av);
            alarm_r <= alarm_en & (fc_nxt != FC_NONE);
            fc_r <= fc_nxt;
        end
    end

    assign sw_norm_on = sw_n_r;
    assign sw_alt_on = sw_a_r;
    assign ind_avail = avail;
    assign ind_active = act_r;
    assign ind_pref = pref_sel;
    assign ind_retx = retx_en;
    assign inhibit = inh_r;
    assign alarm = alarm_r;
    assign fault_code = fc_r;

    // gap length tracker, only for checking
    logic [DW-1:0] chk_gap_r;
    always_ff @(posedge clk)
    begin
        if (sys_rst || st_r != ST_GAP)
            chk_gap_r <= '0;
        else
            chk_gap_r <= chk_gap_r + 1'b1;
    end

    property p_break;
        @(posedge clk) disable iff (sys_rst)
        st_r == ST_GAP |=> !(sw_norm_on || sw_alt_on) || st_r == ST_RUN;
    endproperty
    a_break: assert property (p_break)
        else $error("switch driven during transfer gap");

    property p_never_both;
        @(posedge clk) disable iff (sys_rst)
        !(sw_norm_on && sw_alt_on);
    endproperty
    a_never_both: assert property (p_never_both)
        else $error("both sources connected");

    property p_gap_len;
        @(posedge clk) disable iff (sys_rst)
        gap_done |-> chk_gap_r + 1'b1 >= xfer_dly
            || chk_gap_r + 1'b1 >= rnd_dly;
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("transfer gap ended early");

    property p_ctl_dly;
        @(posedge clk) disable iff (sys_rst)
        start && auto_go && pad_en && !act_hard |-> cd_r >= ctl_dly;
    endproperty
    a_ctl_dly: assert property (p_ctl_dly)
        else $error("transfer before control delay");

    property p_load_inh;
        @(posedge clk) disable iff (sys_rst)
        st_r == ST_RUN && load_flt && !manual && !short_lk
        |=> $stable(act_r) ##0 inhibit;
    endproperty
    a_load_inh: assert property (p_load_inh)
        else $error("transfer despite load fault");

    property p_short_hold;
        @(posedge clk) disable iff (sys_rst)
        short_lk && act_r == short_src && st_r == ST_RUN
        |=> act_r == short_src && st_r == ST_RUN;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("left shorted source");

    property p_latch;
        @(posedge clk) disable iff (sys_rst)
        fan_fail ##1 !maint_clr[*2] |-> fan_r ##0 fault_code != FC_NONE;
    endproperty
    a_latch: assert property (p_latch)
        else $error("internal fault not latched");

    property p_alarm;
        @(posedge clk) disable iff (sys_rst)
        alarm_en && (|short_r) |=> alarm && fault_code == FC_SHORT;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("fault without alarm or code");

    property p_no_retx;
        @(posedge clk) disable iff (sys_rst)
        start && !manual && !short_lk && !act_bad |-> retx_en;
    endproperty
    a_no_retx: assert property (p_no_retx)
        else $error("retransfer while disabled");

    property p_manual;
        @(posedge clk) disable iff (sys_rst)
        manual && !short_lk && act_r == man_sel && st_r == ST_RUN
        |=> act_r == $past(man_sel);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual source abandoned");

    c_gap: cover property (@(posedge clk) st_r == ST_GAP ##1 gap_done);
    c_retx: cover property (@(posedge clk) start && retx_go);
    c_load: cover property (@(posedge clk) load_flt && inact_av);
    c_short: cover property (@(posedge clk) ovr_go ##1 short_lk);
endmodule : dst_ctrl

// *** logic/dst_pkg.sv ***
// shared types and constants of the dual source transfer controller
// assumes all sensing flags are levels synchronous to clk
package dst_pkg;
    localparam int DLY_W = 16;
    localparam logic SRC_NORM = 1'b0;
    localparam logic SRC_ALT = 1'b1;
    // fault codes; readout priority high to low is short, open, fan, load, freq, volt
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_SHORT = 4'h1;
    localparam logic [3:0] FC_OPEN = 4'h2;
    localparam logic [3:0] FC_FAN = 4'h3;
    localparam logic [3:0] FC_FREQ = 4'h4;
    localparam logic [3:0] FC_VOLT = 4'h5;
    localparam logic [3:0] FC_LOAD = 4'h6;

    typedef struct packed {
        logic pickup_ok;   // voltage at or above pickup
        logic below_inph;  // below in-phase threshold
        logic below_rnd;   // below random threshold
        logic phase_low;   // some phase out of limits
        logic over_freq;   // above over-frequency setpoint
        logic below_ofpu;  // below over-frequency pickup
        logic under_freq;  // below under-frequency setpoint
        logic above_ufpu;  // above under-frequency pickup
        logic ovl_avg;     // average overload
        logic ovl_peak;    // peak overload
        logic sw_open;     // a switch of this source open
        logic sw_short;    // a switch of this source shorted
    } dst_src_t;

    typedef enum logic {ST_RUN, ST_GAP} dst_state_t;
endpackage : dst_pkg

// *** logic/dst_src_qual.sv ***
// per-source availability and retransfer qualification
// assumes flags synchronous to clk, one instance per source
module dst_src_qual
#(
    parameter int DW = 16
)
(
    input wire logic clk,                    // system clock
    input wire logic sys_rst,                // sync reset, high
    input wire dst_pkg::dst_src_t flg,       // source flags
    input wire logic freq_en,                // frequency sensing on
    input wire logic fpp_en,                 // full phase protection on
    input wire logic [DW-1:0] retx_time,     // qualify time, cycles
    output logic avail,                      // source available
    output logic freq_bad,                   // frequency latched bad
    output logic retx_ok                     // qualified for retransfer
);
    import dst_pkg::*;

    logic of_r;
    logic of_nxt;
    logic uf_r;
    logic uf_nxt;
    logic [DW-1:0] qc_r;
    logic [DW-1:0] qc_nxt;
    wire logic volt_ok;

    // hysteresis: trip at setpoint, release only past pickup
    assign of_nxt = flg.over_freq | (of_r & ~flg.below_ofpu);
    assign uf_nxt = flg.under_freq | (uf_r & ~flg.above_ufpu);
    assign freq_bad = freq_en & (of_r | uf_r);
    assign volt_ok = flg.pickup_ok & ~(fpp_en & flg.phase_low);
    assign avail = volt_ok & ~freq_bad & ~flg.sw_open;
    assign qc_nxt = ~avail ? '0 : (qc_r == '1) ? qc_r : qc_r + 1'b1;
    assign retx_ok = avail & (qc_r >= retx_time);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            of_r <= 1'b0;
            uf_r <= 1'b0;
            qc_r <= '0;
        end
        else
        begin
            of_r <= of_nxt;
            uf_r <= uf_nxt;
            qc_r <= qc_nxt;
        end
    end

    property p_of_hold;
        @(posedge clk) disable iff (sys_rst)
        of_r && !flg.below_ofpu |=> of_r;
    endproperty
    a_of_hold: assert property (p_of_hold)
        else $error("over-frequency released above pickup");

    property p_uf_hold;
        @(posedge clk) disable iff (sys_rst)
        uf_r && !flg.above_ufpu |=> uf_r;
    endproperty
    a_uf_hold: assert property (p_uf_hold)
        else $error("under-frequency released below pickup");

    property p_qual;
        @(posedge clk) disable iff (sys_rst)
        !avail |=> !retx_ok || retx_time == '0;
    endproperty
    a_qual: assert property (p_qual)
        else $error("retransfer qualified without full interval");
endmodule : dst_src_qual
